// [src/dcc_pkg.sv]
// Package with register map, field positions and encodings of the channel control block.
package dcc_pkg;
    // Printed offsets are not all multiples of four, so each is kept as an index; byte address is four times it.
    localparam logic [31:0] CTRL_IDX = 32'h5000351c;
    localparam logic [31:0] ITEM_IDX_IDX = 32'h5000351e;
    localparam logic [31:0] SRC_LO_IDX = 32'h50003520;
    localparam logic [31:0] SRC_HI_IDX = 32'h50003522;
    localparam logic [31:0] DST_LO_IDX = 32'h50003524;
    localparam logic [31:0] DST_HI_IDX = 32'h50003526;
    // Registers not printed in this range, placed in a free window.
    localparam logic [31:0] LEN_IDX = 32'h50003540;
    localparam logic [31:0] INT_CNT_IDX = 32'h50003541;
    localparam logic [31:0] STATUS_IDX = 32'h50003542;
    localparam int ADDR_W = 34;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'h3fff;
    localparam int F_ON = 0;
    localparam int F_WIDTH_LO = 1;
    localparam int F_IRQ_EN = 3;
    localparam int F_TRIG_MODE = 4;
    localparam int F_DST_INC = 5;
    localparam int F_SRC_INC = 6;
    localparam int F_CIRC = 7;
    localparam int F_PRIO_LO = 8;
    localparam int F_SENSE = 13;
    localparam logic [1:0] W_BYTE = 2'h0;
    localparam logic [1:0] W_HALF = 2'h1;
    localparam logic [1:0] W_WORD = 2'h2;
    localparam int NCH = 4;
    localparam logic [1:0] OWN_CH = 2'h1;
    typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_XFER, ST_DONE} dcc_state_t;
    function automatic logic [31:0] dcc_step(input logic [1:0] w);
        case (w)
            W_HALF: dcc_step = 32'h2;
            W_WORD: dcc_step = 32'h4;
            default: dcc_step = 32'h1;
        endcase
    endfunction
endpackage

// [src/dcc_arbiter.sv]
// Fixed-priority arbiter: highest priority value wins, ties go to the lowest channel number.
module dcc_arbiter (
    input wire logic [dcc_pkg::NCH-1:0] req,
    input wire logic [dcc_pkg::NCH*3-1:0] prio,
    output logic [dcc_pkg::NCH-1:0] grant
);
    import dcc_pkg::*;
    logic [2:0] best;
    logic found;
    always_comb begin
        best = 3'h0;
        found = 1'b0;
        grant = '0;
        for (int i = 0; i < NCH; i++) begin
            if (req[i] && (!found || prio[i*3 +: 3] > best)) begin
                best = prio[i*3 +: 3];
                found = 1'b1;
            end
        end
        for (int i = 0; i < NCH; i++) begin
            if (req[i] && prio[i*3 +: 3] == best && grant == '0) begin
                grant[i] = 1'b1;
            end
        end
    end
endmodule

// [src/dcc_addr_gen.sv]
// Address generator: start address plus index times step when increments are on.
module dcc_addr_gen (
    input wire logic [31:0] start,
    input wire logic [15:0] index,
    input wire logic inc_en,
    input wire logic [1:0] width,
    output logic [31:0] addr
);
    import dcc_pkg::*;
    logic [31:0] off;
    always_comb begin
        off = 32'({16'h0, index} * dcc_step(width));
        addr = inc_en ? start + off : start;
    end
endmodule

// [src/dcc_channel.sv]
// One DMA channel: APB register file, request logic, sequencer and arbitration with peers.
module dcc_channel (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic periph_req,
    input wire logic [dcc_pkg::NCH-1:0] other_bus_req,
    input wire logic [dcc_pkg::NCH*3-1:0] other_prio,
    input wire logic bus_done,
    output logic bus_req,
    output logic bus_grant,
    output logic [31:0] src_addr,
    output logic [31:0] dst_addr,
    output logic [1:0] item_width,
    output logic xfer_active,
    output logic irq
);
    import dcc_pkg::*;

    logic [15:0] ctrl_q;
    logic [15:0] src_lo_q;
    logic [15:0] src_hi_q;
    logic [15:0] dst_lo_q;
    logic [15:0] dst_hi_q;
    logic [15:0] len_q;
    logic [15:0] int_cnt_q;
    logic [15:0] item_index_q;
    logic [15:0] item_index_d;
    logic irq_q;
    logic req_s1_q;
    logic req_s2_q;
    logic req_prev_q;
    logic trig_pend_q;
    logic [31:0] rdata_d;
    logic [31:0] prdata_q;
    logic wr_en;
    logic addr_ok;
    logic [NCH-1:0] all_req;
    logic [NCH*3-1:0] all_prio;
    logic [NCH-1:0] grants;
    logic item_done;
    logic last_item;
    logic clear_on;
    dcc_state_t state_q;
    logic [31:0] src_calc;
    logic [31:0] dst_calc;

    // The bus carries the low 32 bits of the byte address; the dropped top bits are equal for every register.
    function automatic logic hit(input logic [31:0] a, input logic [31:0] idx);
        logic [ADDR_W-1:0] ba;
        ba = {idx, 2'b00};
        hit = (a == ba[31:0]);
    endfunction

    wire logic channel_on = ctrl_q[F_ON];
    wire logic trig_mode = ctrl_q[F_TRIG_MODE];
    wire logic edge_sense = ctrl_q[F_SENSE];
    wire logic [1:0] width = ctrl_q[F_WIDTH_LO +: 2];

    // APB slave: zero wait states, unmapped addresses answer with an error.
    assign pready = 1'b1;
    assign addr_ok = hit(paddr, CTRL_IDX) || hit(paddr, ITEM_IDX_IDX) || hit(paddr, SRC_LO_IDX)
        || hit(paddr, SRC_HI_IDX) || hit(paddr, DST_LO_IDX) || hit(paddr, DST_HI_IDX)
        || hit(paddr, LEN_IDX) || hit(paddr, INT_CNT_IDX) || hit(paddr, STATUS_IDX);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign prdata = prdata_q;

    always_comb begin
        rdata_d = 32'h0;
        if (hit(paddr, CTRL_IDX)) rdata_d = {16'h0, ctrl_q};
        else if (hit(paddr, ITEM_IDX_IDX)) rdata_d = {16'h0, item_index_q};
        else if (hit(paddr, SRC_LO_IDX)) rdata_d = {16'h0, src_lo_q};
        else if (hit(paddr, SRC_HI_IDX)) rdata_d = {16'h0, src_hi_q};
        else if (hit(paddr, DST_LO_IDX)) rdata_d = {16'h0, dst_lo_q};
        else if (hit(paddr, DST_HI_IDX)) rdata_d = {16'h0, dst_hi_q};
        else if (hit(paddr, LEN_IDX)) rdata_d = {16'h0, len_q};
        else if (hit(paddr, INT_CNT_IDX)) rdata_d = {16'h0, int_cnt_q};
        else if (hit(paddr, STATUS_IDX)) rdata_d = {28'h0, trig_pend_q, irq_q, xfer_active, bus_req};
    end

    // Read data is registered in the setup cycle so it is stable in the access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rdata_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_lo_q <= 16'h0;
            src_hi_q <= 16'h0;
            dst_lo_q <= 16'h0;
            dst_hi_q <= 16'h0;
            len_q <= 16'h0;
            int_cnt_q <= 16'h0;
        end else if (wr_en) begin
            if (hit(paddr, SRC_LO_IDX)) src_lo_q <= pwdata[15:0];
            if (hit(paddr, SRC_HI_IDX)) src_hi_q <= pwdata[15:0];
            if (hit(paddr, DST_LO_IDX)) dst_lo_q <= pwdata[15:0];
            if (hit(paddr, DST_HI_IDX)) dst_hi_q <= pwdata[15:0];
            if (hit(paddr, LEN_IDX)) len_q <= pwdata[15:0];
            if (hit(paddr, INT_CNT_IDX)) int_cnt_q <= pwdata[15:0];
        end
    end

    // Hardware clear of enable loses to a software write of the control register in the same cycle; the written value is kept.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_en && hit(paddr, CTRL_IDX)) begin
            ctrl_q <= pwdata[15:0] & CTRL_WMASK;
        end else if (clear_on) begin
            ctrl_q[F_ON] <= 1'b0;
        end
    end

    // Peripheral request crosses from outside: two flip-flops before use.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_prev_q <= 1'b0;
        end else begin
            req_s1_q <= periph_req;
            req_s2_q <= req_s1_q;
            req_prev_q <= req_s2_q;
        end
    end

    // A pending trigger is taken by the level, or caught on a rising edge and held.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_pend_q <= 1'b0;
        end else if (!channel_on) begin
            trig_pend_q <= 1'b0;
        end else if (edge_sense && req_s2_q && !req_prev_q) begin
            trig_pend_q <= 1'b1;
        end else if (item_done) begin
            trig_pend_q <= 1'b0;
        end
    end

    wire logic trig_now = edge_sense ? trig_pend_q : req_s2_q;

    assign bus_req = channel_on && (state_q == ST_REQ) && (!trig_mode || trig_now);
    // The own channel's bit of the peer request vector is ignored; only bus_req stands there.
    assign all_req = (other_bus_req & ~(NCH'(1) << OWN_CH)) | (NCH'(bus_req) << OWN_CH);
    always_comb begin
        all_prio = other_prio;
        all_prio[int'(OWN_CH)*3 +: 3] = ctrl_q[F_PRIO_LO +: 3];
    end

    dcc_arbiter u_arb (
        .req(all_req),
        .prio(all_prio),
        .grant(grants)
    );

    assign bus_grant = grants[OWN_CH];
    assign item_done = (state_q == ST_XFER) && bus_done;
    assign last_item = (item_index_q == len_q);
    assign clear_on = item_done && last_item && !ctrl_q[F_CIRC];
    assign xfer_active = (state_q == ST_XFER);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
        end else if (!channel_on) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: state_q <= ST_REQ;
                ST_REQ: if (bus_req && bus_grant) state_q <= ST_XFER;
                ST_XFER: if (bus_done) state_q <= (last_item && !ctrl_q[F_CIRC]) ? ST_DONE : ST_REQ;
                ST_DONE: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_comb begin
        item_index_d = item_index_q;
        if (!channel_on) item_index_d = 16'h0;
        else if (item_done) item_index_d = last_item ? 16'h0 : item_index_q + 16'h1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            item_index_q <= 16'h0;
        end else begin
            item_index_q <= item_index_d;
        end
    end

    // Interrupt is a one-cycle pulse, checked against the index before it advances.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= item_done && ctrl_q[F_IRQ_EN] && (int_cnt_q == item_index_q);
        end
    end
    assign irq = irq_q;

    dcc_addr_gen u_src (
        .start({src_hi_q, src_lo_q}),
        .index(item_index_q),
        .inc_en(ctrl_q[F_SRC_INC]),
        .width(width),
        .addr(src_calc)
    );

    dcc_addr_gen u_dst (
        .start({dst_hi_q, dst_lo_q}),
        .index(item_index_q),
        .inc_en(ctrl_q[F_DST_INC]),
        .width(width),
        .addr(dst_calc)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_addr <= 32'h0;
            dst_addr <= 32'h0;
            item_width <= W_BYTE;
        end else begin
            src_addr <= src_calc;
            dst_addr <= dst_calc;
            item_width <= width;
        end
    end

    // Steps of one item: a granted request, the item in flight, the item finished, the circular wrap.
    sequence s_granted;
        bus_req && bus_grant;
    endsequence
    sequence s_in_flight;
        xfer_active && !bus_req;
    endsequence
    sequence s_item_end;
        item_done && channel_on;
    endsequence
    sequence s_circ_wrap;
        item_done && last_item && ctrl_q[F_CIRC] && channel_on && !wr_en;
    endsequence

    a_normal_stop: assert property (@(posedge pclk) disable iff (!presetn)
        clear_on && !(wr_en && hit(paddr, CTRL_IDX)) |=> !ctrl_q[F_ON] && item_index_q == 16'h0)
        else $error("Enable not cleared after last item.");

    a_circ_keep: assert property (@(posedge pclk) disable iff (!presetn)
        s_circ_wrap |=> ctrl_q[F_ON] && item_index_q == 16'h0)
        else $error("Circular mode did not restart.");

    a_circ_rearm: assert property (@(posedge pclk) disable iff (!presetn)
        s_circ_wrap |=> state_q == ST_REQ)
        else $error("Circular mode did not request the next item.");

    a_src_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_q[F_SRC_INC] |=> src_addr == $past({src_hi_q, src_lo_q}))
        else $error("Source address moved with increment off.");

    a_dst_step: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q[F_DST_INC] && width == W_WORD |=> dst_addr == $past({dst_hi_q, dst_lo_q}) + 32'($past(item_index_q)) * 4)
        else $error("Destination step wrong.");

    a_width_copy: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> item_width == $past(width))
        else $error("Item width output does not follow the control field.");

    a_req_gate: assert property (@(posedge pclk) disable iff (!presetn)
        bus_req |-> channel_on && (!trig_mode || trig_now))
        else $error("Bus request while not allowed.");

    a_grant_own: assert property (@(posedge pclk) disable iff (!presetn)
        bus_grant |-> bus_req)
        else $error("Grant without own request.");

    a_grant_start: assert property (@(posedge pclk) disable iff (!presetn)
        s_granted |=> s_in_flight)
        else $error("Granted request did not start an item.");

    a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        irq |-> $past(ctrl_q[F_IRQ_EN]) && $past(int_cnt_q) == $past(item_index_q) && $past(item_done))
        else $error("Interrupt without its cause.");

    a_irq_single: assert property (@(posedge pclk) disable iff (!presetn)
        irq |=> !irq)
        else $error("Interrupt longer than one cycle.");

    a_index_step: assert property (@(posedge pclk) disable iff (!presetn)
        item_done && !last_item && channel_on |=> item_index_q == $past(item_index_q) + 16'h1)
        else $error("Index did not advance.");

    a_index_hold: assert property (@(posedge pclk) disable iff (!presetn)
        channel_on && !item_done |=> item_index_q == $past(item_index_q))
        else $error("Index moved without a finished item.");

    a_item_close: assert property (@(posedge pclk) disable iff (!presetn)
        s_item_end |=> !xfer_active)
        else $error("Item still in flight after completion.");

    a_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !channel_on |=> state_q == ST_IDLE && !bus_req)
        else $error("Channel active while off.");

    a_off_index: assert property (@(posedge pclk) disable iff (!presetn)
        !channel_on |=> item_index_q == 16'h0)
        else $error("Index not cleared while off.");

    a_edge_catch: assert property (@(posedge pclk) disable iff (!presetn)
        channel_on && edge_sense && req_s2_q && !req_prev_q |=> trig_pend_q || !channel_on)
        else $error("Rising edge request lost.");

    a_edge_clear: assert property (@(posedge pclk) disable iff (!presetn)
        s_item_end |-> edge_sense && req_s2_q && !req_prev_q ##1 1'b1 or 1'b1 ##1 !trig_pend_q)
        else $error("Pending trigger not used up by its item.");
endmodule

// [verif/dcc_far_model.sv]
// Far-side model of the system bus that ends each item access after a set number of stall cycles.
module dcc_far_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic xfer_active,
    input wire logic [3:0] lat,
    output logic bus_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_q;
    // One completion per item; the access stalls for lat cycles before it ends.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 4'h0;
            bus_done <= 1'b0;
        end else begin
            bus_done <= 1'b0;
            if (xfer_active && !bus_done) begin
                if (wait_q >= lat) begin
                    bus_done <= 1'b1;
                    wait_q <= 4'h0;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end
        end
    end
endmodule

// [verif/dma_channel_control_tb.sv]
// Self-checking testbench of one channel: registers, transfers, arbitration and circular trigger mode.
module dma_channel_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dcc_pkg::*;
    localparam logic [31:0] MAP[6] = '{CTRL_IDX, ITEM_IDX_IDX, SRC_LO_IDX, SRC_HI_IDX, DST_LO_IDX, DST_HI_IDX};
    localparam int ARB_CH[4] = '{0, 2, 3, 0};
    localparam int ARB_PRIO[4] = '{3, 3, 4, 2};
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, periph_req, bus_done;
    logic pready, pslverr, bus_req, bus_grant, xfer_active, irq;
    logic [31:0] paddr, pwdata, prdata, src_addr, dst_addr;
    logic [3:0] other_bus_req, lat;
    logic [11:0] other_prio;
    logic [1:0] item_width;
    logic [32:0] rd_q[$];
    logic [65:0] item_q[$];
    int failures = 0;
    int cmp_count = 0;
    int irq_seen = 0;
    int irq_exp = 0;
    int seed = 32'h7d29323e;
    always #5 pclk = ~pclk;
    dcc_channel DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periph_req(periph_req), .other_bus_req(other_bus_req), .other_prio(other_prio),
        .bus_done(bus_done), .bus_req(bus_req), .bus_grant(bus_grant), .src_addr(src_addr),
        .dst_addr(dst_addr), .item_width(item_width), .xfer_active(xfer_active), .irq(irq));
    dcc_far_model far (.pclk(pclk), .presetn(presetn), .xfer_active(xfer_active), .lat(lat), .bus_done(bus_done));
    task automatic chk(input string what, input logic [65:0] exp, input logic [65:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_read(input logic [32:0] exp, input logic [32:0] got);
        chk("read data", 66'(exp), 66'(got));
    endtask
    task automatic chk_item(input logic [65:0] exp, input logic [65:0] got);
        chk("item", exp, got);
    endtask
    task automatic chk_count(input string what, input logic [31:0] exp, input logic [31:0] got);
        chk(what, 66'(exp), 66'(got));
    endtask
    task automatic finish_test;
        if (failures == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic apb(input logic wr_en, input logic [31:0] idx, input logic [31:0] wd, input logic [32:0] exp);
        logic [33:0] ba;
        int n;
        ba = {idx, 2'b00};
        n = 0;
        @(posedge pclk);
        if (!wr_en) rd_q.push_back(exp);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_en;
        paddr <= ba[31:0];
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            finish_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd, 33'h0);
    endtask
    task automatic rd(input logic [31:0] idx, input logic [32:0] exp);
        apb(1'b0, idx, 32'h0, exp);
    endtask
    task automatic wait_items;
        int n;
        n = 0;
        while (item_q.size() > 0 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 2000) begin
            failures++;
            finish_test();
        end
    endtask
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            chk_read(rd_q.pop_front(), {pslverr, prdata});
        end
        if (bus_done === 1'b1 && xfer_active === 1'b1) begin
            if (item_q.size() > 0) begin
                chk_item(item_q.pop_front(), {item_width, src_addr, dst_addr});
            end else begin
                chk_count("unexpected item", 32'h0, 32'h1);
            end
        end
        if (irq === 1'b1) irq_seen++;
    end
    initial begin
        logic [31:0] v, s, d, st, r;
        logic [15:0] n, ic, cw;
        logic [1:0] w;
        presetn <= 1'b0;
        {psel, penable, pwrite, periph_req} <= 4'h0;
        {paddr, pwdata} <= 64'h0;
        {other_bus_req, other_prio, lat} <= 20'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 6; k++) rd(MAP[k], 33'h0);
        rd(32'h5000353f, {1'b1, 32'h0});
        wr(ITEM_IDX_IDX, 32'hffff);
        rd(ITEM_IDX_IDX, 33'h0);
        wr(CTRL_IDX, 32'hc000);
        rd(CTRL_IDX, 33'h0);
        for (int k = 2; k < 6; k++) begin
            v = $random(seed);
            wr(MAP[k], v);
            rd(MAP[k], {17'h0, v[15:0]});
        end
        for (int i = 0; i < 4; i++) begin
            w = 2'(i % 3);
            r = $random(seed);
            s = $random(seed);
            d = $random(seed);
            n = {14'h0, r[4:3]};
            ic = {13'h0, r[7:5]};
            lat <= r[11:8];
            st = (w == W_BYTE) ? 32'h1 : ((w == W_HALF) ? 32'h2 : 32'h4);
            wr(SRC_LO_IDX, {16'h0, s[15:0]});
            wr(SRC_HI_IDX, {16'h0, s[31:16]});
            wr(DST_LO_IDX, {16'h0, d[15:0]});
            wr(DST_HI_IDX, {16'h0, d[31:16]});
            wr(LEN_IDX, {16'h0, n});
            wr(INT_CNT_IDX, {16'h0, ic});
            rd(LEN_IDX, {17'h0, n});
            rd(INT_CNT_IDX, {17'h0, ic});
            for (int k = 0; k <= n; k++) item_q.push_back({w, r[0] ? s + k * st : s, r[1] ? d + k * st : d});
            if (r[2] && ic <= n) irq_exp++;
            other_prio <= 12'(ARB_PRIO[i] << (3 * ARB_CH[i]));
            other_bus_req <= 4'(1 << ARB_CH[i]);
            cw = {5'h0, 3'h3, 1'b0, r[0], r[1], 1'b0, r[2], w, 1'b1};
            wr(CTRL_IDX, {16'h0, cw});
            if (i % 2 == 0) begin
                repeat (8) @(posedge pclk);
                chk_count("blocked items", 32'(n + 1), 32'(item_q.size()));
                chk_count("request grant", 32'h2, {30'h0, bus_req, bus_grant});
                rd(STATUS_IDX, 33'h1);
                other_bus_req <= 4'h0;
            end
            wait_items();
            other_bus_req <= 4'h0;
            rd(CTRL_IDX, {17'h0, cw & 16'hfffe});
            rd(ITEM_IDX_IDX, 33'h0);
            chk_count("irq count", irq_exp, irq_seen);
        end
        lat <= 4'h2;
        s = $random(seed);
        d = $random(seed);
        wr(SRC_LO_IDX, {16'h0, s[15:0]});
        wr(SRC_HI_IDX, {16'h0, s[31:16]});
        wr(DST_LO_IDX, {16'h0, d[15:0]});
        wr(DST_HI_IDX, {16'h0, d[31:16]});
        wr(LEN_IDX, 32'h1);
        cw = {2'h0, 1'b1, 2'h0, 3'h5, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, W_WORD, 1'b1};
        wr(CTRL_IDX, {16'h0, cw});
        // Any item before the first trigger is flagged by the monitor.
        repeat (10) @(posedge pclk);
        for (int k = 0; k < 3; k++) begin
            item_q.push_back({W_WORD, s + (k % 2) * 4, d + (k % 2) * 4});
            periph_req <= 1'b1;
            repeat (12) @(posedge pclk);
            periph_req <= 1'b0;
            repeat (4) @(posedge pclk);
            wait_items();
        end
        rd(CTRL_IDX, {17'h0, cw});
        rd(ITEM_IDX_IDX, 33'h1);
        wr(CTRL_IDX, 32'h0);
        rd(ITEM_IDX_IDX, 33'h0);
        // Level-sensitive trigger, one item, normal mode: enable must clear after it.
        wr(LEN_IDX, 32'h0);
        cw = {2'h0, 1'b0, 2'h0, 3'h1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, W_BYTE, 1'b1};
        wr(CTRL_IDX, {16'h0, cw});
        repeat (10) @(posedge pclk);
        item_q.push_back({W_BYTE, s, d});
        periph_req <= 1'b1;
        wait_items();
        periph_req <= 1'b0;
        rd(CTRL_IDX, {17'h0, cw & 16'hfffe});
        chk_count("irq count", irq_exp, irq_seen);
        finish_test();
    end
endmodule
